// *** design/scsp_clock_select.sv ***
// Decided for this implementation: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/100ps
`include "scsp_regs.svh"
// Clock source selection, fast RC divider, PLL rate model and clock halving.
module scsp_clock_select
  import scsp_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  awaddr,
  input  wire logic [2:0]  awprot,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic [2:0]  arprot,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire scsp_cfg_s   cfg,
  input  wire logic        fast_rc_osc,
  input  wire logic        oscillator_pin_one,
  input  wire logic        secondary_osc_in_pin,
  input  wire logic        low_power_rc_osc,
  output logic             oscillator_pin_two_out,
  output logic             oscillator_pin_two_oe,
  output logic             oscillator_pin_two_gpio_mode,
  output logic             primary_amp_enable,
  output logic             primary_high_gain,
  output logic             secondary_amp_enable,
  output logic [5:0]       fast_rc_tune,
  output logic             pll_active,
  output logic             osc_tick,
  output logic             instruction_clock,
  output logic             peripheral_clock,
  output logic             watchdog_ref_clk,
  output logic             fail_monitor_ref_clk
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ========================================================================
  // Configuration capture
  scsp_cfg_s  cur_cfg;
  logic       cfg_taken;
  scsp_mode_s mode;

  // [RULE5] Power-on source capture.
  // Straps are caught once, in the first cycle after reset release.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cur_cfg   <= '{3'h7, 2'h3, 1'h1};
      cfg_taken <= 1'b0;
    end else if (!cfg_taken) begin
      cur_cfg   <= cfg;
      cfg_taken <= 1'b1;
    end
  end

  // [RULE6] Source code decode.
  assign mode = scsp_decode(cur_cfg.initial_source_select);

  // [RULE5] Strap taken verbatim.
  strap_capture_a: assert property ($rose(cfg_taken) |-> cur_cfg == $past(cfg)) // [RULE5]
    else $error("Straps not captured at reset release.");

  // [RULE8] Erased device default.
  erased_default_a: assert property ( // [RULE8]
    (cur_cfg.initial_source_select == 3'h7) |-> mode.rc_divn && mode.src == scsp_src_fast_rc)
    else $error("Code 111 does not give fast RC divide-by-N.");

  // ========================================================================
  // Software registers
  logic [2:0] rc_divider_select;
  logic [1:0] pll_output_divider;
  logic [4:0] pll_input_divider;
  logic [8:0] pll_feedback_divider;
  logic [5:0] tune;

  wire [31:0] clock_divider_reg_word = {21'h0, rc_divider_select, pll_output_divider, 1'b0,
                             pll_input_divider};
  wire [31:0] fbd_word    = {23'h0, pll_feedback_divider};
  wire [31:0] tune_word   = {26'h0, tune};
  wire [31:0] status_word = {22'h0, cur_cfg.oscillator_pin_two_pin_function_select, pll_active, 2'h0,
                             cur_cfg.primary_osc_mode, 1'b0,
                             cur_cfg.initial_source_select};

  // Returns the word mapped at an address, zero where nothing is mapped.
  function automatic logic [31:0] reg_word(input logic [7:0] a);
    case ({a[7:2], 2'b00})
      `SCSP_ADDR_CLOCK_DIVIDER_REG: return clock_divider_reg_word;
      `SCSP_ADDR_PLL_FEEDBACK_REG: return fbd_word;
      `SCSP_ADDR_TUNE:   return tune_word;
      `SCSP_ADDR_STATUS: return status_word;
      default:           return 32'h0000_0000;
    endcase
  endfunction : reg_word

  // Tells whether an address hits a mapped word.
  function automatic logic reg_hit(input logic [7:0] a);
    case ({a[7:2], 2'b00})
      `SCSP_ADDR_CLOCK_DIVIDER_REG, `SCSP_ADDR_PLL_FEEDBACK_REG, `SCSP_ADDR_TUNE, `SCSP_ADDR_STATUS: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : reg_hit

  // ========================================================================
  // AXI4-Lite write channel
  logic [7:0]  aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        aw_full;
  logic        w_full;

  wire        aw_fire     = awvalid && awready;
  wire        w_fire      = wvalid && wready;
  wire        wr_go       = aw_full && w_full && !bvalid;
  wire        next_aw_full = wr_go ? 1'b0 : (aw_full || aw_fire);
  wire        next_w_full  = wr_go ? 1'b0 : (w_full || w_fire);
  wire [7:0]  wr_addr     = {aw_addr_q[7:2], 2'b00};
  wire [31:0] wr_merged   = scsp_merge(reg_word(aw_addr_q), w_data_q, w_strb_q);

  // Holds address and data independently until both are present.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full   <= 1'b0;
      w_full    <= 1'b0;
      awready   <= 1'b0;
      wready    <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
    end else begin
      aw_full <= next_aw_full;
      w_full  <= next_w_full;
      awready <= !next_aw_full;
      wready  <= !next_w_full;
      if (aw_fire) begin
        aw_addr_q <= awaddr;
      end
      if (w_fire) begin
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end
    end
  end

  // Issues the write response and clears it on bready.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= `SCSP_RESP_OKAY;
    end else if (wr_go) begin
      bvalid <= 1'b1;
      bresp  <= reg_hit(aw_addr_q) ? `SCSP_RESP_OKAY : `SCSP_RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // [RULE1] [RULE2] Divider and tuning storage.
  // Status is read-only; a write to it is ignored.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rc_divider_select    <= `SCSP_RCDIV_RESET;
      pll_output_divider   <= `SCSP_POST_RESET;
      pll_input_divider    <= `SCSP_PRE_RESET;
      pll_feedback_divider <= `SCSP_FBD_RESET;
      tune                 <= `SCSP_TUNE_RESET;
    end else if (wr_go && wr_addr == `SCSP_ADDR_CLOCK_DIVIDER_REG) begin
      rc_divider_select  <= wr_merged[`SCSP_RCDIV_MSB:`SCSP_RCDIV_LSB];
      pll_output_divider <= wr_merged[`SCSP_POST_MSB:`SCSP_POST_LSB];
      pll_input_divider  <= wr_merged[`SCSP_PRE_MSB:`SCSP_PRE_LSB];
    end else if (wr_go && wr_addr == `SCSP_ADDR_PLL_FEEDBACK_REG) begin
      pll_feedback_divider <= wr_merged[`SCSP_FBD_MSB:0];
    end else if (wr_go && wr_addr == `SCSP_ADDR_TUNE) begin
      tune <= wr_merged[`SCSP_TUNE_MSB:0];
    end
  end

  // [RULE2] Tuning reaches the oscillator trim.
  assign fast_rc_tune = tune;

  sequence tune_write_s;
    wr_go && wr_addr == `SCSP_ADDR_TUNE && w_strb_q[0];
  endsequence
  // [RULE2] Tune write applied.
  tune_write_a: assert property (tune_write_s |=> fast_rc_tune == $past(w_data_q[5:0])) // [RULE2]
    else $error("Tuning write did not reach the trim output.");

  sequence wr_pending_s;
    aw_full && w_full && !bvalid;
  endsequence
  write_resp_a: assert property (wr_pending_s |=> bvalid) // bus
    else $error("Write response not given one cycle after both halves.");

  // ========================================================================
  // AXI4-Lite read channel
  wire ar_fire      = arvalid && arready;
  wire next_rvalid  = ar_fire ? 1'b1 : (rvalid && !rready);

  // Answers a read one cycle after the address is taken.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= `SCSP_RESP_OKAY;
    end else begin
      arready <= !next_rvalid;
      rvalid  <= next_rvalid;
      if (ar_fire) begin
        rdata <= reg_word(araddr);
        rresp <= reg_hit(araddr) ? `SCSP_RESP_OKAY : `SCSP_RESP_SLVERR;
      end
    end
  end

  read_answer_a: assert property (ar_fire |=> rvalid && !arready) // bus
    else $error("Read answer not given one cycle after the address.");

  // ========================================================================
  // Source sampling and edges
  logic frc_q;
  logic pin1_q;
  logic secondary_osc_q;
  logic low_power_rc_osc_q;

  // Remembers the previous level of each synchronous source input.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frc_q  <= 1'b0;
      pin1_q <= 1'b0;
      secondary_osc_q <= 1'b0;
      low_power_rc_osc_q <= 1'b0;
    end else begin
      frc_q  <= fast_rc_osc;
      pin1_q <= oscillator_pin_one;
      secondary_osc_q <= secondary_osc_in_pin;
      low_power_rc_osc_q <= low_power_rc_osc;
    end
  end

  // [RULE7] Primary mode decode.
  // Mode 11 is not a valid primary mode and gives no clock.
  wire pmode_ok = cur_cfg.primary_osc_mode != 2'h3;
  wire crystal  = mode.src == scsp_src_primary &&
                  (cur_cfg.primary_osc_mode == `SCSP_PMODE_XT ||
                   cur_cfg.primary_osc_mode == `SCSP_PMODE_HS);
  wire frc_rise  = fast_rc_osc && !frc_q;
  wire pin1_rise = oscillator_pin_one && !pin1_q && pmode_ok;
  wire secondary_osc_rise = secondary_osc_in_pin && !secondary_osc_q;
  wire low_power_rc_osc_rise = low_power_rc_osc && !low_power_rc_osc_q;

  // Selects the raw tick of the chosen source.
  wire src_tick = (mode.src == scsp_src_primary)      ? pin1_rise :
                  (mode.src == scsp_src_secondary)    ? secondary_osc_rise :
                  (mode.src == scsp_src_low_power_rc) ? low_power_rc_osc_rise : frc_rise;

  // ========================================================================
  // Fast RC divider
  logic div_tick;
  wire  rc_div_mode = mode.rc_div16 || mode.rc_divn;
  // [RULE1] [RULE6] Divide by 16 or by two to the power of select plus one.
  wire [8:0] div_half = mode.rc_div16 ? `SCSP_RC16_HALF : (9'h001 << rc_divider_select);

  scsp_edge_div #(.W(9)) u_rc_div (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .tick     (rc_div_mode && frc_rise),
    .half     (div_half),
    .out_tick (div_tick)
  );

  // [RULE6] Divide-by-16 spacing.
  rc_div16_gap_a: assert property ((mode.rc_div16 && div_tick) |=> !div_tick[*8]) // [RULE6]
    else $error("Divide-by-16 output ticks too close together.");

  // ========================================================================
  // PLL rate model
  logic [11:0] acc;
  // [RULE17] Prescale is field plus 2, multiplier is field plus 2.
  wire [5:0]  n1    = {1'b0, pll_input_divider} + `SCSP_PRE_OFFSET;
  wire [9:0]  m_fac = {1'b0, pll_feedback_divider} + `SCSP_FBD_OFFSET;
  // [RULE14] [RULE19] Postscale of 2, 4 or 8.
  wire [3:0]  n2    = scsp_post_factor(pll_output_divider);
  // [RULE11] Prescale and postscale form the divisor.
  wire [9:0]  den   = {4'h0, n1} * {6'h00, n2};
  // [RULE4] Only fast RC and primary may feed the PLL.
  wire pll_in_tick  = mode.use_pll && src_tick &&
                      (mode.src == scsp_src_fast_rc || mode.src == scsp_src_primary);
  // [RULE13] [RULE16] Each input edge adds M; each output edge spends N1 times N2.
  wire [12:0] acc_sum  = {1'b0, acc} + (pll_in_tick ? {3'h0, m_fac} : 13'h0000);
  wire        nco_tick = mode.use_pll && (acc_sum >= {3'h0, den});
  wire [12:0] acc_left = nco_tick ? (acc_sum - {3'h0, den}) : acc_sum;
  wire [11:0] next_acc = acc_left[12] ? 12'hFFF : acc_left[11:0];

  // Keeps the rate accumulator, cleared outside PLL modes.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc <= 12'h000;
    end else if (!mode.use_pll) begin
      acc <= 12'h000;
    end else begin
      acc <= next_acc;
    end
  end

  // [RULE16] Output edge needs budget.
  pll_ratio_a: assert property ((mode.use_pll && !pll_in_tick) |=> acc <= $past(acc)) // [RULE16]
    else $error("PLL budget grew without an input edge.");

  // ========================================================================
  // Oscillator output and derived clocks
  wire next_osc_tick = mode.use_pll ? nco_tick : (rc_div_mode ? div_tick : src_tick);

  // [RULE9] Instruction and peripheral clocks toggle once per oscillator period.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_tick          <= 1'b0;
      instruction_clock <= 1'b0;
      peripheral_clock  <= 1'b0;
      pll_active        <= 1'b0;
    end else begin
      osc_tick <= next_osc_tick;
      pll_active <= mode.use_pll;
      if (osc_tick) begin
        instruction_clock <= ~instruction_clock;
        peripheral_clock  <= ~peripheral_clock;
      end
    end
  end

  // [RULE9] Halving of oscillator output.
  instr_half_a: assert property ( // [RULE9]
    osc_tick |=> instruction_clock != $past(instruction_clock) &&
                 peripheral_clock == instruction_clock)
    else $error("Instruction clock did not toggle on an oscillator tick.");

  // [RULE4] PLL source restriction.
  pll_source_a: assert property ( // [RULE4]
    pll_active |-> $past(mode.src) inside {scsp_src_fast_rc, scsp_src_primary})
    else $error("PLL active on a source that may not use it.");

  // [RULE3] Low-power RC reference copies.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      watchdog_ref_clk     <= 1'b0;
      fail_monitor_ref_clk <= 1'b0;
    end else begin
      watchdog_ref_clk     <= low_power_rc_osc;
      fail_monitor_ref_clk <= low_power_rc_osc;
    end
  end

  // [RULE3] Both references follow the low-power RC.
  low_power_rc_osc_ref_a: assert property ( // [RULE3]
    $past(aresetn) |->
      watchdog_ref_clk == $past(low_power_rc_osc) && fail_monitor_ref_clk == watchdog_ref_clk)
    else $error("Reference clocks do not follow the low-power RC.");

  // ========================================================================
  // Oscillator amplifiers and pin two
  // [RULE7] [RULE18] Crystal owns pin two; otherwise the config bit picks its use.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      primary_amp_enable     <= 1'b0;
      primary_high_gain      <= 1'b0;
      secondary_amp_enable   <= 1'b0;
      oscillator_pin_two_out <= 1'b0;
      oscillator_pin_two_oe  <= 1'b0;
      oscillator_pin_two_gpio_mode         <= 1'b0;
    end else begin
      primary_amp_enable     <= crystal;
      primary_high_gain      <= crystal && cur_cfg.primary_osc_mode == `SCSP_PMODE_HS;
      secondary_amp_enable   <= mode.src == scsp_src_secondary;
      oscillator_pin_two_out <= instruction_clock;
      oscillator_pin_two_oe  <= !crystal && cur_cfg.oscillator_pin_two_pin_function_select;
      oscillator_pin_two_gpio_mode         <= !crystal && !cur_cfg.oscillator_pin_two_pin_function_select;
    end
  end

  // [RULE18] Crystal releases pin two.
  crystal_release_a: assert property ( // [RULE18]
    primary_amp_enable |-> !oscillator_pin_two_oe && !oscillator_pin_two_gpio_mode)
    else $error("Pin two driven while a crystal is attached.");

  // [RULE18] Clock out on pin two.
  pin2_clock_a: assert property ( // [RULE18]
    oscillator_pin_two_oe |-> oscillator_pin_two_out == $past(instruction_clock))
    else $error("Pin two does not carry the instruction clock.");

  // [RULE7] High gain only with a crystal.
  hs_gain_a: assert property (primary_high_gain |-> primary_amp_enable) // [RULE7]
    else $error("High gain set without the primary amplifier.");
endmodule : scsp_clock_select

// *** design/scsp_edge_div.sv ***
`timescale 1ns/100ps
// Divides a stream of rising-edge ticks by twice the half count.
module scsp_edge_div
  import scsp_pkg::*;
#(
  parameter int W = 9
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         tick,
  input  wire logic [W-1:0] half,
  output logic              out_tick
);
  logic [W-1:0] count;
  logic         level;

  // ========================================================================
  // Half-period wrap detection.
  wire [W-1:0] next_count = count + {{(W-1){1'b0}}, 1'b1};
  wire         wrap       = tick && (next_count >= half);

  // Counts ticks and toggles the divided level, pulsing on its rising edge.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count    <= '0;
      level    <= 1'b0;
      out_tick <= 1'b0;
    end else begin
      out_tick <= wrap && !level;
      if (wrap) begin
        count <= '0;
        level <= ~level;
      end else if (tick) begin
        count <= next_count;
      end
    end
  end
endmodule : scsp_edge_div

// *** shared/scsp_pkg.sv ***
package scsp_pkg;
  `include "scsp_regs.svh"

  // ========================================================================
  // Types
  typedef enum logic [1:0] {
    scsp_src_fast_rc,
    scsp_src_primary,
    scsp_src_secondary,
    scsp_src_low_power_rc
  } scsp_src_e;

  typedef struct packed {
    logic [2:0] initial_source_select;
    logic [1:0] primary_osc_mode;
    logic       oscillator_pin_two_pin_function_select;
  } scsp_cfg_s;

  typedef struct packed {
    scsp_src_e src;
    logic      use_pll;
    logic      rc_div16;
    logic      rc_divn;
  } scsp_mode_s;

  // ========================================================================
  // Decodes the initial source select code into source kind and path.
  function automatic scsp_mode_s scsp_decode(input logic [2:0] sel);
    scsp_mode_s m;
    m.src      = scsp_src_fast_rc;
    m.use_pll  = 1'b0;
    m.rc_div16 = 1'b0;
    m.rc_divn  = 1'b0;
    case (sel)
      `SCSP_SRC_FRC_PLL: m.use_pll = 1'b1;
      `SCSP_SRC_PRI: m.src = scsp_src_primary;
      `SCSP_SRC_PRI_PLL: begin
        m.src     = scsp_src_primary;
        m.use_pll = 1'b1;
      end
      `SCSP_SRC_SEC: m.src = scsp_src_secondary;
      `SCSP_SRC_LOW_POWER_RC_OSC: m.src = scsp_src_low_power_rc;
      `SCSP_SRC_FRC_DIV16: m.rc_div16 = 1'b1;
      `SCSP_SRC_FRC_DIVN: m.rc_divn = 1'b1;
      default: m.src = scsp_src_fast_rc;
    endcase
    return m;
  endfunction : scsp_decode

  // Maps the output divider code to its factor; the reserved code divides by 8.
  function automatic logic [3:0] scsp_post_factor(input logic [1:0] post);
    case (post)
      `SCSP_POST_DIV2: return 4'h2;
      `SCSP_POST_DIV4: return 4'h4;
      default: return 4'h8;
    endcase
  endfunction : scsp_post_factor

  // Merges write data into an old word under the byte strobes.
  function automatic logic [31:0] scsp_merge(input logic [31:0] old_w,
                                             input logic [31:0] new_w,
                                             input logic [3:0]  strb);
    logic [31:0] r;
    r = old_w;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    return r;
  endfunction : scsp_merge
endpackage : scsp_pkg

// *** shared/scsp_regs.svh ***
`ifndef SCSP_REGS_SVH
`define SCSP_REGS_SVH
// Functional notes
// [RULE1] Fast RC clock divided by 1:2 up to 1:256 from a three-bit divider field.
// [RULE2] Software can adjust the fast RC frequency through a tuning value.
// [RULE3] Low-power RC clock feeds watchdog and clock fail monitor, and is a source.
// [RULE4] Only fast RC and primary sources may pass through the PLL.
// [RULE5] At power-on the source comes from initial select and primary mode fields.
// [RULE6] Select codes: RC, RC+PLL, primary, primary+PLL, secondary, LP RC, RC/16, RC/N.
// [RULE7] Primary mode 00 external clock, 01 crystal, 10 high-speed crystal.
// [RULE8] An erased device starts in fast RC divide-by-N, select code 111.
// [RULE9] Instruction and peripheral clocks are the oscillator output halved.
// [RULE10] Software keeps the instruction clock at or below 40 MHz.
// [RULE11] PLL input divided by a prescale of 2 to 33 from a five-bit field.
// [RULE12] Software keeps the VCO input between 0.8 MHz and 8 MHz.
// [RULE13] VCO input multiplied by M from nine bits; VCO stays 100 to 200 MHz.
// [RULE14] VCO output divided by 2, 4 or 8 from a two-bit output field.
// [RULE15] Software keeps the PLL output between 12.5 MHz and 80 MHz.
// [RULE16] PLL output equals input times M over prescale times postscale.
// [RULE17] Field offsets: prescale is value plus 2, multiplier is value plus 2.
// [RULE18] In internal, secondary and external modes a config bit sets pin two use.
// [RULE19] Output divider 00 is 2, 01 is 4, 11 is 8, 10 reserved.

// ==========================================================================
// Register offsets
`define SCSP_ADDR_CLOCK_DIVIDER_REG    8'h00
`define SCSP_ADDR_PLL_FEEDBACK_REG    8'h04
`define SCSP_ADDR_TUNE      8'h08
`define SCSP_ADDR_STATUS    8'h0C

// ==========================================================================
// Field positions
`define SCSP_RCDIV_MSB      10
`define SCSP_RCDIV_LSB      8
`define SCSP_POST_MSB       7
`define SCSP_POST_LSB       6
`define SCSP_PRE_MSB        4
`define SCSP_PRE_LSB        0
`define SCSP_FBD_MSB        8
`define SCSP_TUNE_MSB       5

// ==========================================================================
// Reset values and factor offsets
`define SCSP_RCDIV_RESET    3'h0
`define SCSP_POST_RESET     2'h1
`define SCSP_PRE_RESET      5'h00
`define SCSP_FBD_RESET      9'h030
`define SCSP_TUNE_RESET     6'h00
`define SCSP_PRE_OFFSET     6'h02
`define SCSP_FBD_OFFSET     10'h002
`define SCSP_RC16_HALF      9'h008

// ==========================================================================
// Source select codes, primary modes and output divider codes
`define SCSP_SRC_FRC        3'h0
`define SCSP_SRC_FRC_PLL    3'h1
`define SCSP_SRC_PRI        3'h2
`define SCSP_SRC_PRI_PLL    3'h3
`define SCSP_SRC_SEC        3'h4
`define SCSP_SRC_LOW_POWER_RC_OSC       3'h5
`define SCSP_SRC_FRC_DIV16  3'h6
`define SCSP_SRC_FRC_DIVN   3'h7
`define SCSP_PMODE_EC       2'h0
`define SCSP_PMODE_XT       2'h1
`define SCSP_PMODE_HS       2'h2
`define SCSP_POST_DIV2      2'h0
`define SCSP_POST_DIV4      2'h1
`define SCSP_POST_DIV8      2'h3

// ==========================================================================
// Bus responses
`define SCSP_RESP_OKAY      2'h0
`define SCSP_RESP_SLVERR    2'h2
`endif

// *** verification/scsp_ext_clock_model.sv ***
`timescale 1ns/100ps
// ==========================================================================
// External clock source on pin one, running freely like a real oscillator.
module scsp_ext_clock_model #(
  parameter int HALF_LOG = 2
) (
  input  wire logic aclk,
  output logic      clk_out
);
  logic [7:0] cnt = 8'h00;

  // The chosen counter bit forms a square wave of period 2**(HALF_LOG+1).
  always @(posedge aclk) begin
    cnt <= cnt + 8'h01;
  end
  assign clk_out = cnt[HALF_LOG];
endmodule : scsp_ext_clock_model

// *** verification/scsp_tb.sv ***
`timescale 1ns/100ps
`include "scsp_regs.svh"
// ==========================================================================
// Boots every source select code, programs the dividers and counts output ticks.
module tb
  import scsp_pkg::*;
;
  localparam logic [5:0] CFGS [9] = '{6'h39, 6'h00, 6'h09, 6'h11, 6'h1B, 6'h15, 6'h21, 6'h2F, 6'h31};
  localparam int         TICKS [9] = '{16, 256, 128, 64, 32, 64, 32, 64, 16};
  localparam logic [2:0] FLAGS [9] = '{3'h1, 3'h0, 3'h5, 3'h1, 3'h6, 3'h2, 3'h1, 3'h1, 3'h1};
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00, cnt = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, pll_active, primary_amp_enable;
  logic        oscillator_pin_two_oe, osc_tick, instruction_clock, watchdog_ref_clk, pin_one;
  logic [1:0]  bresp, rresp;
  logic [5:0]  fast_rc_tune;
  scsp_cfg_s   cfg = 6'h39;
  int          mismatches = 0, comparisons = 0;

  // Clock, and internal sources made from one counter (fast RC, low-power RC, secondary).
  always #12.5 aclk = ~aclk;
  always @(posedge aclk) cnt <= cnt + 8'h01;

  scsp_ext_clock_model #(.HALF_LOG(2)) ext (.aclk(aclk), .clk_out(pin_one));
  scsp_clock_select dut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .cfg(cfg), .fast_rc_osc(cnt[0]), .oscillator_pin_one(pin_one),
    .secondary_osc_in_pin(cnt[3]), .low_power_rc_osc(cnt[2]), .oscillator_pin_two_out(),
    .oscillator_pin_two_oe(oscillator_pin_two_oe), .oscillator_pin_two_gpio_mode(),
    .primary_amp_enable(primary_amp_enable), .primary_high_gain(), .secondary_amp_enable(),
    .fast_rc_tune(fast_rc_tune), .pll_active(pll_active), .osc_tick(osc_tick),
    .instruction_clock(instruction_clock), .peripheral_clock(), .watchdog_ref_clk(watchdog_ref_clk),
    .fail_monitor_ref_clk());

  task automatic summarize;
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : summarize

  task automatic tmo;
    mismatches++;
    $display("FAIL %0t bus wait ran out", $time);
    summarize();
  endtask : tmo

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // Tick counts allow two for the partial periods at the window edges.
  task automatic chk_cnt(input int got, input int exp, input string what);
    comparisons++;
    if (got < exp - 2 || got > exp + 2) begin
      mismatches++;
      $display("FAIL %0t %s count %0d expected %0d", $time, what, got, exp);
    end
  endtask : chk_cnt

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 40);
    bready <= 1'b0;
    if (n >= 40) tmo();
    chk({30'h0, bresp}, {30'h0, `SCSP_RESP_OKAY}, "bresp");
    @(posedge aclk);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    int n;
    n = 0;
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 40);
    rready <= 1'b0;
    if (n >= 40) tmo();
    chk(rdata, e, "rdata");
    chk({30'h0, rresp}, {30'h0, r}, "rresp");
    @(posedge aclk);
  endtask : rd

  task automatic boot(input logic [5:0] c);
    aresetn <= 1'b0;
    cfg     <= c;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
  endtask : boot

  task automatic measure(input int t, input logic [2:0] f);
    int   ticks, rises, wd;
    logic ic, lp;
    ticks = 0;
    rises = 0;
    wd    = 0;
    for (int i = 0; i < 512; i++) begin
      @(posedge aclk);
      ticks += int'(osc_tick === 1'b1);
      rises += int'(instruction_clock === 1'b1 && ic === 1'b0);
      if (i > 0 && watchdog_ref_clk !== lp) wd++;
      ic = instruction_clock;
      lp = cnt[2];
    end
    chk_cnt(ticks, t, "ticks");
    chk_cnt(rises, t / 2, "instruction clock");
    chk_cnt(wd, 0, "watchdog ref");
    chk({29'h0, pll_active, primary_amp_enable, oscillator_pin_two_oe}, {29'h0, f}, "flags");
  endtask : measure

  // Main sequence: one boot per strap row, register checks on the first.
  initial begin
    for (int r = 0; r < 9; r++) begin
      boot(CFGS[r]);
      if (r == 0) begin
        rd(`SCSP_ADDR_CLOCK_DIVIDER_REG, 32'h40, 2'h0);
        rd(`SCSP_ADDR_PLL_FEEDBACK_REG, 32'h30, 2'h0);
        rd(8'h10, 32'h0, `SCSP_RESP_SLVERR);
        rd(`SCSP_ADDR_TUNE, 32'h0, 2'h0);
        wr(`SCSP_ADDR_TUNE, 32'h15);
        chk({26'h0, fast_rc_tune}, 32'h15, "tune");
      end
      rd(`SCSP_ADDR_STATUS, {22'h0, CFGS[r][0], FLAGS[r][2], 2'h0, CFGS[r][2:1], 1'h0, CFGS[r][5:3]}, 2'h0);
      wr(`SCSP_ADDR_PLL_FEEDBACK_REG, 32'h1E);
      wr(`SCSP_ADDR_CLOCK_DIVIDER_REG, 32'h3C6);
      repeat (200) @(posedge aclk);
      measure(TICKS[r], FLAGS[r]);
      $display("Test %0d done", r);
    end
    summarize();
  end
endmodule : tb
